/* hdl/dcl_lookup.v */
// Device context lookup: originator tag to domain parameters through root and context tables.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "dcl_map.vh"

module dcl_lookup #(
	parameter SEGMENT_ID = 16'h0000,
	parameter ADDR_W     = 64
) (
	// Clock and reset
	input  wire                      clk,
	input  wire                      rst_b,
	// Register port
	input  wire [7:0]                reg_addr,
	input  wire [31:0]               reg_wdata,
	input  wire                      reg_wr,
	input  wire                      reg_rd,
	output reg  [31:0]               reg_rdata_q,
	output reg                       irq_q,
	// Inbound request
	input  wire                      req_valid,
	output reg                       req_ready_q,
	input  wire [15:0]               req_segment,
	input  wire [15:0]               req_originator_tag,
	input  wire                      req_ari,
	input  wire                      req_is_write,
	input  wire [ADDR_W-1:0]         req_incoming_dma_address,
	// Table memory read port
	output reg                       mem_rd_req_q,
	output reg  [63:0]               mem_rd_addr_q,
	input  wire                      mem_rd_ack,
	input  wire [`DCL_ENTRY_W-1:0]   mem_rd_data,
	// Downstream translation stage
	output reg                       out_valid_q,
	input  wire                      out_ready,
	output reg  [15:0]               out_originator_tag_q,
	output reg  [4:0]                out_device_q,
	output reg  [7:0]                out_function_q,
	output reg                       out_is_write_q,
	output reg  [ADDR_W-1:0]         out_incoming_dma_address_q,
	output reg  [15:0]               out_domain_tag_q,
	output reg  [1:0]                out_translation_kind_q,
	output reg  [2:0]                out_address_width_q,
	output reg  [51:0]               out_structure_root_q,
	output reg                       out_fault_suppress_q,
	// Blocked request report
	output reg                       fault_valid_q,
	output reg  [1:0]                fault_code_q,
	output reg                       fault_suppressed_q,
	output reg  [15:0]               fault_originator_tag_q
);

	localparam [5:0] S_IDLE = 6'b000001;
	localparam [5:0] S_ROOT = 6'b000010;
	localparam [5:0] S_CTX  = 6'b000100;
	localparam [5:0] S_OUT  = 6'b001000;
	localparam [5:0] S_FLT  = 6'b010000;
	localparam [5:0] S_CHK  = 6'b100000;

	reg  [5:0]               state_q;
	reg  [31:0]              ctrl_q;
	reg  [31:0]              root_lo_q;
	reg  [31:0]              root_hi_q;
	reg  [`DCL_ST_W-1:0]     status_q;
	reg  [`DCL_ST_W-1:0]     mask_q;
	reg  [17:0]              fault_info_q;
	reg  [15:0]              tag_q;
	reg                      ari_q;
	reg                      is_write_q;
	reg  [ADDR_W-1:0]        dma_addr_q;
	reg                      seg_ok_q;
	reg  [1:0]               flt_code_q;
	reg                      flt_supp_q;
	reg  [`DCL_ST_W-1:0]     events_d;
	reg  [`DCL_ST_W-1:0]     status_d;
	reg  [31:0]              rdata_d;

	wire                     enable;
	wire [63:0]              root_base;
	wire                     take;
	wire [63:0]              ctx_ptr;

	assign enable    = ctrl_q[`DCL_CTRL_ENABLE];
	assign root_base = {root_hi_q, root_lo_q[31:`DCL_TABLE_ALIGN], {`DCL_TABLE_ALIGN{1'b0}}};
	assign take      = req_valid && req_ready_q;
	assign ctx_ptr   = {mem_rd_data[`DCL_RE_PTR_HI:`DCL_RE_PTR_LO], {`DCL_TABLE_ALIGN{1'b0}}};

	// Lookup sequencer.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q                    <= S_IDLE;
			req_ready_q                <= 1'b0;
			mem_rd_req_q               <= 1'b0;
			mem_rd_addr_q              <= 64'h0;
			tag_q                      <= 16'h0;
			ari_q                      <= 1'b0;
			is_write_q                 <= 1'b0;
			dma_addr_q                 <= {ADDR_W{1'b0}};
			seg_ok_q                   <= 1'b0;
			flt_code_q                 <= `DCL_FLT_NONE;
			flt_supp_q                 <= 1'b0;
			out_valid_q                <= 1'b0;
			out_originator_tag_q       <= 16'h0;
			out_device_q               <= 5'h0;
			out_function_q             <= 8'h0;
			out_is_write_q             <= 1'b0;
			out_incoming_dma_address_q <= {ADDR_W{1'b0}};
			out_domain_tag_q           <= 16'h0;
			out_translation_kind_q     <= 2'h0;
			out_address_width_q        <= 3'h0;
			out_structure_root_q       <= 52'h0;
			out_fault_suppress_q       <= 1'b0;
			fault_valid_q              <= 1'b0;
			fault_code_q               <= `DCL_FLT_NONE;
			fault_suppressed_q         <= 1'b0;
			fault_originator_tag_q     <= 16'h0;
		end else begin
			fault_valid_q <= 1'b0;
			case (state_q)
				S_IDLE: begin
					req_ready_q <= enable;
					if (take) begin
						req_ready_q <= 1'b0;
						tag_q       <= req_originator_tag;
						ari_q       <= req_ari;
						is_write_q  <= req_is_write;
						dma_addr_q  <= req_incoming_dma_address;
						seg_ok_q    <= (req_segment == SEGMENT_ID);
						state_q     <= S_CHK;
					end
				end
				S_CHK: begin
					if (!seg_ok_q) begin
						flt_code_q <= `DCL_FLT_SEG;
						flt_supp_q <= 1'b0;
						state_q    <= S_FLT;
					end else begin
						mem_rd_req_q  <= 1'b1;
						mem_rd_addr_q <= root_base + {48'h0, tag_q[15:8], 4'h0};
						state_q       <= S_ROOT;
					end
				end
				S_ROOT: begin
					if (mem_rd_ack) begin
						if (!mem_rd_data[`DCL_RE_PRESENT]) begin
							mem_rd_req_q <= 1'b0;
							flt_code_q   <= `DCL_FLT_ROOT;
							flt_supp_q   <= 1'b0;
							state_q      <= S_FLT;
						end else begin
							mem_rd_addr_q <= ctx_ptr + {48'h0, tag_q[7:0], 4'h0};
							state_q       <= S_CTX;
						end
					end
				end
				S_CTX: begin
					if (mem_rd_ack) begin
						mem_rd_req_q <= 1'b0;
						if (!mem_rd_data[`DCL_CE_PRESENT]) begin
							flt_code_q <= `DCL_FLT_CTX;
							flt_supp_q <= mem_rd_data[`DCL_CE_FPD];
							state_q    <= S_FLT;
						end else begin
							out_valid_q                <= 1'b1;
							out_originator_tag_q       <= tag_q;
							out_device_q               <= ari_q ? 5'h00 : tag_q[7:3];
							out_function_q             <= ari_q ? tag_q[7:0] : {5'h00, tag_q[2:0]};
							out_is_write_q             <= is_write_q;
							out_incoming_dma_address_q <= dma_addr_q;
							out_domain_tag_q           <= mem_rd_data[`DCL_CE_DID_HI:`DCL_CE_DID_LO];
							out_translation_kind_q     <= mem_rd_data[`DCL_CE_TT_HI:`DCL_CE_TT_LO];
							out_address_width_q        <= mem_rd_data[`DCL_CE_AW_HI:`DCL_CE_AW_LO];
							out_structure_root_q       <= mem_rd_data[`DCL_CE_ASR_HI:`DCL_CE_ASR_LO];
							out_fault_suppress_q       <= mem_rd_data[`DCL_CE_FPD];
							state_q                    <= S_OUT;
						end
					end
				end
				S_OUT: begin
					if (out_ready) begin
						out_valid_q <= 1'b0;
						req_ready_q <= enable;
						state_q     <= S_IDLE;
					end
				end
				S_FLT: begin
					fault_valid_q          <= 1'b1;
					fault_code_q           <= flt_code_q;
					fault_suppressed_q     <= flt_supp_q;
					fault_originator_tag_q <= tag_q;
					req_ready_q            <= enable;
					state_q                <= S_IDLE;
				end
				default: begin
					mem_rd_req_q <= 1'b0;
					out_valid_q  <= 1'b0;
					req_ready_q  <= 1'b0;
					state_q      <= S_IDLE;
				end
			endcase
		end
	end

	// Events for the status register; a suppressed fault sets no status bit.
	always @* begin
		events_d = {`DCL_ST_W{1'b0}};
		events_d[`DCL_ST_DONE] = (state_q == S_OUT) && out_ready;
		if ((state_q == S_FLT) && !flt_supp_q) begin
			events_d[`DCL_ST_ROOT_FLT] = (flt_code_q == `DCL_FLT_ROOT);
			events_d[`DCL_ST_CTX_FLT]  = (flt_code_q == `DCL_FLT_CTX);
			events_d[`DCL_ST_SEG_FLT]  = (flt_code_q == `DCL_FLT_SEG);
		end
		status_d = status_q;
		if (reg_wr && (reg_addr == `DCL_REG_STATUS)) begin
			status_d = status_d & ~reg_wdata[`DCL_ST_W-1:0];
		end
		status_d = status_d | events_d;
	end

	// Read data multiplexer; unmapped offsets read zero.
	always @* begin
		case (reg_addr)
			`DCL_REG_CTRL:    rdata_d = ctrl_q;
			`DCL_REG_ROOT_LO: rdata_d = {root_lo_q[31:`DCL_TABLE_ALIGN], {`DCL_TABLE_ALIGN{1'b0}}};
			`DCL_REG_ROOT_HI: rdata_d = root_hi_q;
			`DCL_REG_STATUS:  rdata_d = {{(32-`DCL_ST_W){1'b0}}, status_q};
			`DCL_REG_MASK:    rdata_d = {{(32-`DCL_ST_W){1'b0}}, mask_q};
			`DCL_REG_FAULT:   rdata_d = {14'h0, fault_info_q};
			`DCL_REG_STATE:   rdata_d = {26'h0, state_q};
			default:          rdata_d = 32'h0;
		endcase
	end

	// Register file.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q       <= `DCL_CTRL_RESET;
			root_lo_q    <= 32'h0;
			root_hi_q    <= 32'h0;
			status_q     <= {`DCL_ST_W{1'b0}};
			mask_q       <= `DCL_MASK_RESET;
			fault_info_q <= 18'h0;
			reg_rdata_q  <= 32'h0;
			irq_q        <= 1'b0;
		end else begin
			status_q <= status_d;
			irq_q    <= |(status_d & mask_q);
			if (reg_rd) begin
				reg_rdata_q <= rdata_d;
			end else begin
				reg_rdata_q <= 32'h0;
			end
			if ((state_q == S_FLT) && !flt_supp_q) begin
				fault_info_q <= {flt_code_q, tag_q};
			end
			if (reg_wr) begin
				case (reg_addr)
					`DCL_REG_CTRL:    ctrl_q    <= {31'h0, reg_wdata[`DCL_CTRL_ENABLE]};
					`DCL_REG_ROOT_LO: root_lo_q <= reg_wdata;
					`DCL_REG_ROOT_HI: root_hi_q <= reg_wdata;
					`DCL_REG_MASK:    mask_q    <= reg_wdata[`DCL_ST_W-1:0];
					default: begin
					end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

/* hdl/dcl_map.vh */
// Register offsets, field positions, reset values and table geometry of the context lookup.
`ifndef DCL_MAP_VH
`define DCL_MAP_VH

`define DCL_REG_CTRL      8'h00
`define DCL_REG_ROOT_LO   8'h04
`define DCL_REG_ROOT_HI   8'h08
`define DCL_REG_STATUS    8'h0C
`define DCL_REG_MASK      8'h10
`define DCL_REG_FAULT     8'h14
`define DCL_REG_STATE     8'h18

`define DCL_CTRL_ENABLE   0
`define DCL_CTRL_RESET    32'h0000_0000
`define DCL_MASK_RESET    4'h0

`define DCL_ST_DONE       0
`define DCL_ST_ROOT_FLT   1
`define DCL_ST_CTX_FLT    2
`define DCL_ST_SEG_FLT    3
`define DCL_ST_W          4

`define DCL_FLT_NONE      2'h0
`define DCL_FLT_ROOT      2'h1
`define DCL_FLT_CTX       2'h2
`define DCL_FLT_SEG       2'h3

`define DCL_TABLE_ALIGN   12
`define DCL_ENTRY_SHIFT   4
`define DCL_ENTRY_W       128

`define DCL_RE_PRESENT    0
`define DCL_RE_PTR_LO     12
`define DCL_RE_PTR_HI     63

`define DCL_CE_PRESENT    0
`define DCL_CE_FPD        1
`define DCL_CE_TT_LO      2
`define DCL_CE_TT_HI      3
`define DCL_CE_ASR_LO     12
`define DCL_CE_ASR_HI     63
`define DCL_CE_AW_LO      64
`define DCL_CE_AW_HI      66
`define DCL_CE_DID_LO     72
`define DCL_CE_DID_HI     87

`endif

/* testbench/dcl_lookup_asserts.sv */
// Port checker of the device context lookup.
`timescale 1ns/10ps
`default_nettype none
module dcl_lookup_asserts #(
	parameter SEGMENT_ID = 16'h0000
) (
	// Clock and reset
	input wire logic         clk,
	input wire logic         rst_b,
	// Request and table port
	input wire logic         req_valid,
	input wire logic         req_ready_q,
	input wire logic [15:0]  req_segment,
	input wire logic [15:0]  req_originator_tag,
	input wire logic         mem_rd_req_q,
	input wire logic [63:0]  mem_rd_addr_q,
	input wire logic         mem_rd_ack,
	input wire logic [127:0] mem_rd_data,
	// Results
	input wire logic         out_valid_q,
	input wire logic         out_ready,
	input wire logic [15:0]  out_originator_tag_q,
	input wire logic [15:0]  out_domain_tag_q,
	input wire logic [1:0]   out_translation_kind_q,
	input wire logic [51:0]  out_structure_root_q,
	input wire logic         fault_valid_q,
	input wire logic [1:0]   fault_code_q,
	input wire logic         fault_suppressed_q
);
	logic [15:0] tag_q;
	logic        ctx_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Tracks the tag in flight and whether the root entry has been answered.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tag_q <= 16'h0000;
			ctx_q <= 1'b0;
		end else if (req_valid && req_ready_q) begin
			tag_q <= req_originator_tag;
			ctx_q <= 1'b0;
		end else if (mem_rd_ack) begin
			ctx_q <= 1'b1;
		end
	end
	sequence s_take;
		req_valid && req_ready_q;
	endsequence
	sequence s_root_ack;
		mem_rd_ack && !ctx_q;
	endsequence
	sequence s_ctx_ack;
		mem_rd_ack && ctx_q;
	endsequence
	AST_SEG_FAULT: assert property (s_take ##0 (req_segment != SEGMENT_ID) |-> ##3 fault_valid_q && fault_code_q == 2'h3) else $error("segment fault missing");
	AST_ROOT_ADDR: assert property (s_take ##0 (req_segment == SEGMENT_ID) |-> ##2 mem_rd_req_q && mem_rd_addr_q[11:0] == {tag_q[15:8], 4'h0}) else $error("root entry address wrong");
	AST_CTX_ADDR: assert property (s_root_ack ##0 mem_rd_data[0] |=> mem_rd_req_q && mem_rd_addr_q == {$past(mem_rd_data[63:12]), tag_q[7:0], 4'h0}) else $error("device entry address wrong");
	AST_ROOT_ABSENT: assert property (s_root_ack ##0 !mem_rd_data[0] |=> !mem_rd_req_q ##1 fault_valid_q && fault_code_q == 2'h1) else $error("root absent fault missing");
	AST_CTX_ABSENT: assert property (s_ctx_ack ##0 !mem_rd_data[0] |-> ##2 fault_valid_q && fault_code_q == 2'h2 && fault_suppressed_q == $past(mem_rd_data[1], 2)) else $error("device absent fault wrong");
	AST_CTX_OUT: assert property (s_ctx_ack ##0 mem_rd_data[0] |=> out_valid_q && out_structure_root_q == $past(mem_rd_data[63:12]) && out_translation_kind_q == $past(mem_rd_data[3:2]) && out_domain_tag_q == $past(mem_rd_data[87:72])) else $error("domain fields wrong");
	AST_OUT_HOLD: assert property (out_valid_q && !out_ready |=> out_valid_q && $stable(out_structure_root_q) && $stable(out_domain_tag_q)) else $error("result dropped while stalled");
	AST_OUT_TAG: assert property (out_valid_q |-> out_originator_tag_q == tag_q && !req_ready_q) else $error("result tag wrong");
endmodule
bind dcl_lookup dcl_lookup_asserts #(.SEGMENT_ID(SEGMENT_ID)) u_chk (.clk, .rst_b, .req_valid, .req_ready_q, .req_segment, .req_originator_tag, .mem_rd_req_q, .mem_rd_addr_q, .mem_rd_ack, .mem_rd_data, .out_valid_q, .out_ready, .out_originator_tag_q, .out_domain_tag_q, .out_translation_kind_q, .out_structure_root_q, .fault_valid_q, .fault_code_q, .fault_suppressed_q);
`default_nettype wire

/* testbench/dcl_mem_model.sv */
// Table memory model that answers entry reads after a settable latency.
`timescale 1ns/10ps
`default_nettype none
module dcl_mem_model (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Entry read port
	input  wire logic         rd_req,
	input  wire logic [63:0]  rd_addr,
	output var  logic         ack,
	output var  logic [127:0] data
);
	logic [127:0] mem [longint];
	int           lat = 0;
	int           cnt;
	// Outside an answer the data lines toggle, so a stale entry is never held steady.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack <= 1'b0;
			data <= '0;
			cnt <= 0;
		end else if (rd_req && !ack && cnt >= lat) begin
			ack <= 1'b1;
			data <= mem.exists(rd_addr) ? mem[rd_addr] : '0;
			cnt <= 0;
		end else begin
			ack <= 1'b0;
			data <= ~data;
			cnt <= (rd_req && !ack) ? cnt + 1 : 0;
		end
	end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench of the device context lookup.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk, rst_b, reg_wr, reg_rd, req_valid, req_ari, req_is_write, out_ready;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic [15:0] req_segment, req_originator_tag;
	logic [63:0] req_incoming_dma_address;
	logic [3:0]  msk;
	wire  [31:0] reg_rdata_q;
	wire         irq_q, req_ready_q, mem_rd_req_q, mem_rd_ack, out_valid_q, out_is_write_q;
	wire         out_fault_suppress_q, fault_valid_q, fault_suppressed_q;
	wire  [63:0] mem_rd_addr_q, out_incoming_dma_address_q;
	wire [127:0] mem_rd_data;
	wire  [15:0] out_originator_tag_q, out_domain_tag_q, fault_originator_tag_q;
	wire  [7:0]  out_function_q;
	wire  [4:0]  out_device_q;
	wire  [1:0]  out_translation_kind_q, fault_code_q;
	wire  [2:0]  out_address_width_q;
	wire  [51:0] out_structure_root_q;
	int          errors = 0, n_checks = 0, cyc = 0;
	dcl_lookup DUT (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .irq_q,
		.req_valid, .req_ready_q, .req_segment, .req_originator_tag, .req_ari, .req_is_write,
		.req_incoming_dma_address, .mem_rd_req_q, .mem_rd_addr_q, .mem_rd_ack, .mem_rd_data,
		.out_valid_q, .out_ready, .out_originator_tag_q, .out_device_q, .out_function_q,
		.out_is_write_q, .out_incoming_dma_address_q, .out_domain_tag_q, .out_translation_kind_q,
		.out_address_width_q, .out_structure_root_q, .out_fault_suppress_q, .fault_valid_q,
		.fault_code_q, .fault_suppressed_q, .fault_originator_tag_q);
	dcl_mem_model MEM (.clk(clk), .rst_b(rst_b), .rd_req(mem_rd_req_q), .rd_addr(mem_rd_addr_q),
		.ack(mem_rd_ack), .data(mem_rd_data));
	task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		if (a == 8'h10) msk = d[3:0];
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	// A status read also compares the interrupt line against the masked status.
	task automatic rd(logic [7:0] a, logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check("reg_rdata_q", reg_rdata_q, e);
		if (a == 8'h0C) check("irq_q", irq_q, |(e[3:0] & msk));
		@(posedge clk);
	endtask
	// Holds the request until taken, then waits a bounded time for a result or fault.
	task automatic send(logic [15:0] t, logic [15:0] s, logic a);
		req_originator_tag <= t;
		req_segment <= s;
		req_ari <= a;
		req_is_write <= t[0];
		req_incoming_dma_address <= {48'h0, t};
		req_valid <= 1'b1;
		#1 while (req_ready_q !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		req_valid <= 1'b0;
		repeat (40) begin
			@(posedge clk);
			#1 if (out_valid_q === 1'b1 || fault_valid_q === 1'b1) return;
		end
		check("result", 1'b0, 1'b1);
	endtask
	task automatic t_regs();
		rd(8'h00, 32'h0);
		rd(8'h10, 32'h0);
		rd(8'h1C, 32'h0);
		wr(8'h04, 32'h0001_0FFF);
		rd(8'h04, 32'h0001_0000);
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h1);
		$display("test regs done");
	endtask
	task automatic t_hits();
		for (int k = 0; k < 4; k++) begin
			MEM.lat = 3 * k;
			send({8'h12, 8'h30 + 8'(k)}, 16'h0, k[0]);
			check("kind", out_translation_kind_q, k);
			check("root", out_structure_root_q, 52'h55);
			check("width", out_address_width_q, 3'h2);
			check("domain", out_domain_tag_q, 16'h00A5);
			check("fsup", out_fault_suppress_q, k[1]);
			check("func", out_function_q, k[0] ? 8'h30 + k : k);
			check("dev", out_device_q, k[0] ? 5'h00 : 5'h06);
			check("addr", out_incoming_dma_address_q, {56'h12, 8'h30 + 8'(k)});
			check("wr", out_is_write_q, k[0]);
			check("otag", out_originator_tag_q, {8'h12, 8'h30 + 8'(k)});
			repeat (2) @(posedge clk);
			out_ready <= 1'b1;
			@(posedge clk);
			out_ready <= 1'b0;
		end
		$display("test hits done");
	endtask
	task automatic t_faults();
		wr(8'h10, 32'h6);
		wr(8'h0C, 32'hF);
		send(16'h3300, 16'h0, 1'b0);
		check("code", fault_code_q, 2'h1);
		check("ftag", fault_originator_tag_q, 16'h3300);
		@(posedge clk);
		rd(8'h0C, 32'h2);
		rd(8'h14, 32'h0001_3300);
		wr(8'h0C, 32'h2);
		send(16'h1240, 16'h0, 1'b0);
		check("supp", {fault_suppressed_q, fault_code_q}, 3'h6);
		@(posedge clk);
		rd(8'h0C, 32'h0);
		rd(8'h14, 32'h0001_3300);
		send(16'h1241, 16'h0, 1'b0);
		check("supp", {fault_suppressed_q, fault_code_q}, 3'h2);
		check("ftag", fault_originator_tag_q, 16'h1241);
		@(posedge clk);
		rd(8'h0C, 32'h4);
		wr(8'h0C, 32'h4);
		send(16'h1234, 16'h1, 1'b0);
		check("code", fault_code_q, 2'h3);
		@(posedge clk);
		rd(8'h0C, 32'h8);
		wr(8'h10, 32'h8);
		rd(8'h0C, 32'h8);
		$display("test faults done");
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		{rst_b, reg_wr, reg_rd, req_valid, req_ari, req_is_write, out_ready} = '0;
		{reg_addr, reg_wdata, req_segment, req_originator_tag, req_incoming_dma_address} = '0;
		msk = 4'h0;
		MEM.mem[64'h10120] = 128'h2_0001;
		// All entries of domain tag A5 share one translation structure root.
		for (int k = 0; k < 4; k++)
			MEM.mem[64'h20300 + 16 * k] = {40'h0, 16'h00A5, 5'h0, 3'h2, 52'h55, 8'h0, 2'(k), k[1], 1'b1};
		MEM.mem[64'h20400] = 128'h2;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_hits();
		t_faults();
		conclude();
	end
endmodule
`default_nettype wire
